/* logic/csi_params.svh */
`ifndef CSI_PARAMS_SVH
`define CSI_PARAMS_SVH

// Register offsets
`define CSI_A_PIN_STATUS 8'h41
`define CSI_A_TOP_IRQ 8'h42
`define CSI_A_GLOBAL_FUNC 8'h43
`define CSI_A_INPUT_SUM 8'h44
`define CSI_A_OUT_SUM_LOW 8'h45
`define CSI_A_OUT_SUM_HIGH 8'h46
`define CSI_A_PLL_SUM 8'h47
`define CSI_A_PLL1_STATUS 8'h48
`define CSI_A_PLL2_STATUS 8'h49
`define CSI_A_PLL1_IE 8'h4A
`define CSI_A_PLL2_IE 8'h4B

// Field positions
`define CSI_B_FREQ_LOW_L 7
`define CSI_B_FREQ_LOW 6
`define CSI_B_FREQ_HIGH_L 5
`define CSI_B_FREQ_HIGH 4
`define CSI_B_LOCK_L 3
`define CSI_B_LOCK 2
`define CSI_B_REF 0
`define CSI_B_BOOT_DONE 7
`define CSI_B_GLOBAL_IE 1
`define CSI_B_TOP_INT 0
`define CSI_B_TOP_PLL 2
`define CSI_B_TOP_IN 4
`define CSI_B_TOP_OUT 5

// Writable masks and reset values
`define CSI_M_PLL_IE 8'hA8
`define CSI_M_PLL_W1C 8'hA8
`define CSI_M_PIN_IE 8'h0F
`define CSI_R_ZERO 8'h00

`endif

/* logic/csi_pkg.sv */
package csi_pkg;

	typedef struct packed {
		logic freq_low_now;
		logic freq_high_now;
		logic pll_locked;
		logic reference_in_use;
	} csi_pll_src_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csi_bus_req_s;

	typedef logic [7:0] csi_byte_t;

endpackage : csi_pkg

/* logic/csi_irq_status.sv */
`timescale 1ns/1ns
`include "csi_params.svh"

// Behaviour
// - Register writes are ignored while auto-configuration runs.
// - Global functions bits 3..0 enable each pin-change latch interrupt.
// - Input summary bit 3 is crystal change latch AND its enable.
// - Input summary bits 2..0 are input change latches AND enables.
// - Low output summary: one bit per output 1..8, any enabled latch.
// - High output summary: outputs 10 and 9 in bits 1,0; rest zero.
// - PLL summary bit 0 for PLL one, bit 1 for PLL two.
// - Bit 7 latches on frequency-low rise, cleared by writing one.
// - Bit 6 shows frequency-low in real time.
// - Bit 5 latches on frequency-high rise, cleared by writing one.
// - Bit 4 shows frequency-high in real time.
// - Bit 3 latches on any lock change, cleared by writing one.
// - Bit 2 shows lock state in real time.
// - Bit 0 shows the reference in use, 1 is alternate.
// - PLL two status register mirrors PLL one layout and behaviour.
// - Enable bits 7, 5, 3 gate low, high and lock latches.
// - PLL two enable register mirrors PLL one.
// - Global flag set by enabled summaries or enabled pin latches.
// - Pin change latch sets on either edge, cleared by writing one.
// - Input change latch sets on valid change only, after clear.
module csi_irq_status #(
	parameter int NUM_PLL = 2,
	parameter int NUM_PIN = 4,
	parameter int NUM_IN = 4,
	parameter int NUM_OUT = 10
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic auto_config_busy,
	input wire csi_pkg::csi_bus_req_s bus_req,
	output csi_pkg::csi_byte_t rdata,
	output logic rvalid,
	input wire csi_pkg::csi_pll_src_s [NUM_PLL-1:0] pll_src,
	input wire logic [NUM_PIN-1:0] pin_state,
	input wire logic [NUM_IN-1:0] input_valid_change_latch,
	input wire logic [NUM_IN-1:0] input_valid_irq_enable,
	input wire logic [NUM_OUT-1:0] output_enabled_latch_any,
	output logic global_irq
);
	import csi_pkg::*;

	////////////////////////////////////////////////////////////////
	// Input synchronisers, three stages
	csi_pll_src_s [NUM_PLL-1:0] pll_s1_r, pll_s2_r, pll_s3_r;
	logic [NUM_PIN-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
	logic boot_s1_r, boot_s2_r, boot_s3_r;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pll_s1_r <= '0;
			pll_s2_r <= '0;
			pll_s3_r <= '0;
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
			boot_s1_r <= 1'b1;
			boot_s2_r <= 1'b1;
			boot_s3_r <= 1'b1;
		end else begin
			pll_s1_r <= pll_src;
			pll_s2_r <= pll_s1_r;
			pll_s3_r <= pll_s2_r;
			pin_s1_r <= pin_state;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			boot_s1_r <= auto_config_busy;
			boot_s2_r <= boot_s1_r;
			boot_s3_r <= boot_s2_r;
		end
	end

	// Filtered levels: update only when stages two and three agree
	csi_pll_src_s [NUM_PLL-1:0] pll_now_r;
	logic [NUM_PIN-1:0] pin_now_r;
	logic boot_busy_r;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pll_now_r <= '0;
			pin_now_r <= '0;
			boot_busy_r <= 1'b1;
		end else begin
			if (pll_s2_r == pll_s3_r) begin
				pll_now_r <= pll_s3_r;
			end
			if (pin_s2_r == pin_s3_r) begin
				pin_now_r <= pin_s3_r;
			end
			if (boot_s2_r == boot_s3_r) begin
				boot_busy_r <= boot_s3_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Write decode; nothing lands while auto-configuration runs
	logic wr_ok;
	logic wr_top;
	logic wr_glob;
	logic wr_pin;

	assign wr_ok = bus_req.wr && !boot_busy_r;
	assign wr_top = wr_ok && bus_req.addr == `CSI_A_TOP_IRQ;
	assign wr_glob = wr_ok && bus_req.addr == `CSI_A_GLOBAL_FUNC;
	assign wr_pin = wr_ok && bus_req.addr == `CSI_A_PIN_STATUS;

	////////////////////////////////////////////////////////////////
	// Enable registers
	logic [7:0] pin_ie_r;
	logic [7:0] pll_ie_r [NUM_PLL];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_ie_r <= `CSI_R_ZERO;
		end else if (wr_glob) begin
			pin_ie_r <= bus_req.wdata & `CSI_M_PIN_IE;
		end
	end

	logic global_ie_r;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			global_ie_r <= 1'b0;
		end else if (wr_top) begin
			global_ie_r <= bus_req.wdata[`CSI_B_GLOBAL_IE];
		end
	end

	////////////////////////////////////////////////////////////////
	// Per PLL status and enables
	logic [7:0] pll_latch_r [NUM_PLL];
	logic [7:0] pll_status [NUM_PLL];
	logic [NUM_PLL-1:0] pll_sum;
	csi_pll_src_s pll_prev_r [NUM_PLL];

	genvar g;
	generate
		for (g = 0; g < NUM_PLL; g++) begin : g_pll
			logic [7:0] p_addr;
			logic [7:0] ie_addr;
			logic [7:0] set_v;
			logic [7:0] clr_v;
			logic wr_status;
			logic wr_ie;

			assign p_addr = (g == 0) ? `CSI_A_PLL1_STATUS : `CSI_A_PLL2_STATUS;
			assign ie_addr = (g == 0) ? `CSI_A_PLL1_IE : `CSI_A_PLL2_IE;
			assign wr_status = wr_ok && bus_req.addr == p_addr;
			assign wr_ie = wr_ok && bus_req.addr == ie_addr;

			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					pll_ie_r[g] <= `CSI_R_ZERO;
				end else if (wr_ie) begin
					pll_ie_r[g] <= bus_req.wdata & `CSI_M_PLL_IE;
				end
			end

			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					pll_prev_r[g] <= '0;
				end else begin
					pll_prev_r[g] <= pll_now_r[g];
				end
			end

			always_comb begin
				set_v = '0;
				set_v[`CSI_B_FREQ_LOW_L] = pll_now_r[g].freq_low_now
					&& !pll_prev_r[g].freq_low_now;
				set_v[`CSI_B_FREQ_HIGH_L] = pll_now_r[g].freq_high_now
					&& !pll_prev_r[g].freq_high_now;
				set_v[`CSI_B_LOCK_L] = pll_now_r[g].pll_locked
					^ pll_prev_r[g].pll_locked;
				clr_v = wr_status ? (bus_req.wdata & `CSI_M_PLL_W1C) : '0;
			end

			// Set wins over clear; a zero write keeps the latch
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					pll_latch_r[g] <= `CSI_R_ZERO;
				end else begin
					pll_latch_r[g] <= set_v | (pll_latch_r[g] & ~clr_v);
				end
			end

			always_comb begin
				pll_status[g] = pll_latch_r[g];
				pll_status[g][`CSI_B_FREQ_LOW] = pll_now_r[g].freq_low_now;
				pll_status[g][`CSI_B_FREQ_HIGH] = pll_now_r[g].freq_high_now;
				pll_status[g][`CSI_B_LOCK] = pll_now_r[g].pll_locked;
				pll_status[g][`CSI_B_REF] = pll_now_r[g].reference_in_use;
			end

			assign pll_sum[g] = |(pll_latch_r[g] & pll_ie_r[g]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Pin change latches
	logic [NUM_PIN-1:0] pin_prev_r;
	logic [NUM_PIN-1:0] pin_latch_r;
	logic [NUM_PIN-1:0] pin_clr;

	assign pin_clr = wr_pin ? bus_req.wdata[NUM_PIN*2-1:NUM_PIN] : '0;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_prev_r <= '0;
			pin_latch_r <= '0;
		end else begin
			pin_prev_r <= pin_now_r;
			pin_latch_r <= (pin_now_r ^ pin_prev_r) | (pin_latch_r & ~pin_clr);
		end
	end

	////////////////////////////////////////////////////////////////
	// Summaries
	logic [7:0] in_sum, out_low, out_high, pll_sum_b, top_b, pin_b, glob_b;
	logic pin_irq;

	always_comb begin
		in_sum = '0;
		in_sum[NUM_IN-1:0] = input_valid_change_latch
			& input_valid_irq_enable;
		out_low = output_enabled_latch_any[7:0];
		out_high = '0;
		out_high[NUM_OUT-9:0] = output_enabled_latch_any[NUM_OUT-1:8];
		pll_sum_b = '0;
		pll_sum_b[NUM_PLL-1:0] = pll_sum;
	end

	// Pin-change requests bypass the global enable
	always_comb begin
		pin_irq = |(pin_latch_r & pin_ie_r[NUM_PIN-1:0]);
		top_b = '0;
		top_b[`CSI_B_TOP_OUT] = |out_low;
		top_b[`CSI_B_TOP_IN] = |in_sum;
		top_b[`CSI_B_TOP_PLL] = |pll_sum_b;
		top_b[`CSI_B_GLOBAL_IE] = global_ie_r;
		top_b[`CSI_B_TOP_INT] = ((|out_low | |out_high | |in_sum | |pll_sum_b) && global_ie_r)
			|| pin_irq;
	end

	always_comb begin
		pin_b = {pin_latch_r, pin_now_r};
		glob_b = pin_ie_r;
		glob_b[`CSI_B_BOOT_DONE] = !boot_busy_r;
	end

	////////////////////////////////////////////////////////////////
	// Interrupt output, registered
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			global_irq <= 1'b0;
		end else begin
			global_irq <= top_b[`CSI_B_TOP_INT];
		end
	end

	////////////////////////////////////////////////////////////////
	// Read select; unmapped addresses read as zero
	csi_byte_t rd_nxt;

	always_comb begin
		unique case (bus_req.addr)
			`CSI_A_PIN_STATUS: rd_nxt = pin_b;
			`CSI_A_TOP_IRQ: rd_nxt = top_b;
			`CSI_A_GLOBAL_FUNC: rd_nxt = glob_b;
			`CSI_A_INPUT_SUM: rd_nxt = in_sum;
			`CSI_A_OUT_SUM_LOW: rd_nxt = out_low;
			`CSI_A_OUT_SUM_HIGH: rd_nxt = out_high;
			`CSI_A_PLL_SUM: rd_nxt = pll_sum_b;
			`CSI_A_PLL1_STATUS: rd_nxt = pll_status[0];
			`CSI_A_PLL2_STATUS: rd_nxt = pll_status[NUM_PLL-1];
			`CSI_A_PLL1_IE: rd_nxt = pll_ie_r[0];
			`CSI_A_PLL2_IE: rd_nxt = pll_ie_r[NUM_PLL-1];
			default: rd_nxt = `CSI_R_ZERO;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Read port, one cycle latency
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata <= `CSI_R_ZERO;
			rvalid <= 1'b0;
		end else begin
			rvalid <= bus_req.rd;
			if (bus_req.rd) begin
				rdata <= rd_nxt;
			end
		end
	end

endmodule : csi_irq_status

/* verification/csi_irq_status_checker.sv */
`timescale 1ns/1ns
module csi_irq_status_checker #(
	parameter int NUM_PLL = 2,
	parameter int NUM_PIN = 4,
	parameter int NUM_IN = 4,
	parameter int NUM_OUT = 10
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire csi_pkg::csi_bus_req_s bus_req,
	input wire csi_pkg::csi_byte_t rdata,
	input wire logic rvalid,
	input wire csi_pkg::csi_pll_src_s [NUM_PLL-1:0] pll_src,
	input wire logic [NUM_IN-1:0] input_valid_change_latch,
	input wire logic [NUM_IN-1:0] input_valid_irq_enable,
	input wire logic [NUM_OUT-1:0] output_enabled_latch_any
);
	import csi_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_rvalid; bus_req.rd |=> rvalid; endproperty
	a_rvalid: assert property (p_rvalid) else $error("no read answer");
	property p_rvalid_cause; rvalid |-> $past(bus_req.rd); endproperty
	a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");
	property p_in_sum;
		bus_req.rd && bus_req.addr == 8'h44 |=>
			rdata == {4'h0, $past(input_valid_change_latch & input_valid_irq_enable)};
	endproperty
	a_in_sum: assert property (p_in_sum) else $error("input summary wrong");
	property p_out_low; bus_req.rd && bus_req.addr == 8'h45 |=>
		rdata == $past(output_enabled_latch_any[7:0]); endproperty
	a_out_low: assert property (p_out_low) else $error("low output summary wrong");
	property p_out_high; bus_req.rd && bus_req.addr == 8'h46 |=>
		rdata == {6'h00, $past(output_enabled_latch_any[9:8])}; endproperty
	a_out_high: assert property (p_out_high) else $error("high output summary wrong");
	property p_pll_sum; bus_req.rd && bus_req.addr == 8'h47 |=> rdata[7:2] == 6'h00; endproperty
	a_pll_sum: assert property (p_pll_sum) else $error("pll summary spare bits");
	property p_ie_mask; bus_req.rd && bus_req.addr inside {8'h4A, 8'h4B} |=>
		(rdata & 8'h57) == 8'h00; endproperty
	a_ie_mask: assert property (p_ie_mask) else $error("enable spare bits");
	property p_pll1; $stable(pll_src)[*8] ##0 (bus_req.rd && bus_req.addr == 8'h48) |=>
		{rdata[6], rdata[4], rdata[2], rdata[0]} == $past(pll_src[0]) && !rdata[1]; endproperty
	a_pll1: assert property (p_pll1) else $error("pll1 live");
	property p_pll2; $stable(pll_src)[*8] ##0 (bus_req.rd && bus_req.addr == 8'h49) |=>
		{rdata[6], rdata[4], rdata[2], rdata[0]} == $past(pll_src[1]) && !rdata[1]; endproperty
	a_pll2: assert property (p_pll2) else $error("pll two live bits");
endmodule : csi_irq_status_checker
////////////////////////////////////////////////////////////////
bind csi_irq_status csi_irq_status_checker #(.NUM_PLL(NUM_PLL), .NUM_PIN(NUM_PIN),
	.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_csi_irq_status_checker (.clk_sys, .rstn,
	.bus_req, .rdata, .rvalid, .pll_src, .input_valid_change_latch, .input_valid_irq_enable,
	.output_enabled_latch_any);

/* verification/tb.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
	import csi_pkg::*;
	logic clk_sys, rstn, auto_config_busy, rvalid, global_irq;
	csi_bus_req_s bus_req;
	csi_byte_t rdata, d;
	csi_pll_src_s [1:0] pll_src;
	logic [3:0] pin_state, input_valid_change_latch, input_valid_irq_enable;
	logic [9:0] output_enabled_latch_any;
	int n_errors = 0;
	int checks_done = 0;
	csi_irq_status u_csi_irq_status (.clk_sys, .rstn, .auto_config_busy, .bus_req, .rdata,
		.rvalid, .pll_src, .pin_state, .input_valid_change_latch, .input_valid_irq_enable,
		.output_enabled_latch_any, .global_irq);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	task results;
		if (n_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task wr(input csi_byte_t a, input csi_byte_t v);
		@(posedge clk_sys) bus_req <= '{1'b1, 1'b0, a, v};
		@(posedge clk_sys) bus_req <= '0;
	endtask : wr
	task rd(input csi_byte_t a, output csi_byte_t v);
		@(posedge clk_sys) bus_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys) bus_req <= '0;
		#1;
		`CHK(rvalid, 1'b1)
		v = rdata;
	endtask : rd
	task rchk(input csi_byte_t a, input csi_byte_t e);
		rd(a, d);
		`CHK(d, e)
	endtask : rchk
	task t_reset;
		for (int a = 8'h44; a <= 8'h4B; a++) rchk(8'(a), 8'h00);
		rchk(8'h60, 8'h00);
	endtask : t_reset
	task t_busy;
		tick(8);
		wr(8'h43, 8'h08);
		rchk(8'h43, 8'h00);
		@(posedge clk_sys) auto_config_busy <= 1'b0;
		for (int i = 0; i < 20 && d[3] !== 1'b1; i++) begin
			wr(8'h43, 8'h08);
			rd(8'h43, d);
		end
		`CHK(d, 8'h88)
	endtask : t_busy
	task t_pll(input int p);
		csi_byte_t a;
		csi_byte_t ie;
		a = 8'(8'h48 + p);
		ie = 8'(8'h4A + p);
		@(posedge clk_sys) pll_src[p] <= 4'hF;
		tick(10);
		rchk(a, 8'hFD);
		wr(a, 8'h00);
		rchk(a, 8'hFD);
		wr(a, 8'hFF);
		rchk(a, 8'h55);
		wr(ie, 8'hFF);
		rchk(ie, 8'hA8);
		rchk(8'h47, 8'h00);
		@(posedge clk_sys) pll_src[p].pll_locked <= 1'b0;
		tick(10);
		rchk(a, 8'h59);
		rchk(8'h47, 8'(1 << p));
		wr(8'h42, 8'h02);
		tick(2);
		`CHK(global_irq, 1'b1)
		wr(ie, 8'h00);
		rchk(8'h47, 8'h00);
		`CHK(global_irq, 1'b0)
		@(posedge clk_sys) pll_src[p] <= '0;
		tick(10);
		wr(a, 8'hFF);
		rchk(a, 8'h00);
	endtask : t_pll
	task t_io;
		@(posedge clk_sys) begin
			input_valid_change_latch <= 4'hF;
			input_valid_irq_enable <= 4'hA;
			output_enabled_latch_any <= 10'h3A5;
		end
		wr(8'h44, 8'hFF);
		rchk(8'h44, 8'h0A);
		rchk(8'h45, 8'hA5);
		rchk(8'h46, 8'h03);
		`CHK(global_irq, 1'b1)
		rchk(8'h42, 8'h33);
		wr(8'h42, 8'h00);
		tick(1);
		`CHK(global_irq, 1'b0)
		rchk(8'h42, 8'h30);
		@(posedge clk_sys) input_valid_change_latch <= 4'h0;
		rchk(8'h44, 8'h00);
	endtask : t_io
	task t_pin;
		wr(8'h43, 8'h01);
		@(posedge clk_sys) pin_state <= 4'h1;
		tick(8);
		rchk(8'h41, 8'h11);
		`CHK(global_irq, 1'b1)
		wr(8'h43, 8'h00);
		tick(1);
		`CHK(global_irq, 1'b0)
		wr(8'h41, 8'h10);
		rchk(8'h41, 8'h01);
		@(posedge clk_sys) pin_state <= 4'h0;
		tick(8);
		rchk(8'h41, 8'h10);
	endtask : t_pin
	////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		auto_config_busy = 1'b1;
		bus_req = '0;
		pll_src = '0;
		pin_state = 4'h0;
		input_valid_change_latch = 4'h0;
		input_valid_irq_enable = 4'h0;
		output_enabled_latch_any = 10'h000;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset;
		t_busy;
		t_pll(0);
		t_pll(1);
		t_io;
		t_pin;
		results;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		results;
	end
endmodule : tb
